// ===== design/stfr_cfg.svh
// timing constants for the supply tracking fault/retry control
`ifndef STFR_CFG_SVH
`define STFR_CFG_SVH
`define STFR_CLK_NS        100
`define STFR_GATE_TO_NS    1000
`define STFR_GATE_TO_CYC   ((`STFR_GATE_TO_NS + `STFR_CLK_NS - 1) / `STFR_CLK_NS)
`define STFR_FAULT_NS      2000
`define STFR_FAULT_CYC     ((`STFR_FAULT_NS + `STFR_CLK_NS - 1) / `STFR_CLK_NS)
`define STFR_RETRY_NS      3000
`define STFR_RETRY_CYC     ((`STFR_RETRY_NS + `STFR_CLK_NS - 1) / `STFR_CLK_NS)
`define STFR_CNT_W         16
`define STFR_CNT_ONE       16'h0001
`define STFR_CNT_ZERO      16'h0000
`define STFR_NSUP          4
`endif

// ===== design/stfr_pkg.sv
// types for the supply tracking fault/retry control
package stfr_pkg;
  typedef enum logic [1:0]
  {
    STFR_ROLE_SOLO   = 2'b00,
    STFR_ROLE_MASTER = 2'b01,
    STFR_ROLE_SLAVE  = 2'b10
  } stfr_role_t;

  typedef enum logic [2:0]
  {
    STFR_ST_OFF     = 3'b000,
    STFR_ST_GATEWT  = 3'b001,
    STFR_ST_UP      = 3'b010,
    STFR_ST_ON      = 3'b011,
    STFR_ST_DOWN    = 3'b100,
    STFR_ST_FAULT   = 3'b101,
    STFR_ST_RETRY   = 3'b110,
    STFR_ST_LATCHED = 3'b111
  } stfr_state_t;

  typedef struct packed
  {
    stfr_role_t role;
    logic       auto_retry;
    logic [3:0] track_sel;
  } stfr_cfg_t;

  typedef struct packed
  {
    logic track_ok;
    logic track_err;
    logic ramp_done;
    logic outs_low;
  } stfr_analog_t;
endpackage

// ===== design/stfr_timer.sv
// down-counting timer with load and done flag
`timescale 1ns/1ns
`default_nettype none
`include "stfr_cfg.svh"
module stfr_timer
(
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   load_in,
  input  wire logic                   run_in,
  input  wire logic [`STFR_CNT_W-1:0] len_in,
  output logic                        done_out
);
  logic [`STFR_CNT_W-1:0] cnt_ff;
  wire  [`STFR_CNT_W-1:0] nxt_cnt = load_in ? len_in :
    ((run_in && cnt_ff != `STFR_CNT_ZERO) ? cnt_ff - `STFR_CNT_ONE : cnt_ff);
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      cnt_ff <= `STFR_CNT_ZERO;
    else
      cnt_ff <= nxt_cnt;
  end
  // done only once a count has really run out, not straight after a load
  assign done_out = run_in && !load_in && cnt_ff == `STFR_CNT_ONE;
endmodule
`default_nettype wire

// ===== design/stfr_ctrl.sv
// supply tracking fault/retry control, top level
// ==========================================================
// Overview of operation
// - standalone unit waits for drive timeout before every power-up.
// - drive timeout off during power-down and in master or slave role.
// - standalone unit starts retry count when it asserts tracking error.
// - group member starts retry count when shared error line releases.
// - sync-wait line driven low while any selected supply is low.
// - no member starts tracking while shared sync-wait line is low.
// - master holds sync-wait low throughout its retry count.
// - power-up only with track enable high; low forces ramp-down.
// - master drives shared ramp; slaves make no ramp and follow master.
// - tracking error asserted on long failure or ramp deviation.
// - fault timer restarts each sequence, holds its count while tracking is good.
// - power-up only while logic enable high; low forces ramp-down.
`timescale 1ns/1ns
`default_nettype none
`include "stfr_cfg.svh"
module stfr_ctrl
(
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  input  wire stfr_pkg::stfr_cfg_t    cfg_in,
  input  wire logic                   enable_in,
  input  wire logic                   track_enable_comparator_input,
  input  wire logic [`STFR_NSUP-1:0]  supply_ok_in,
  input  wire stfr_pkg::stfr_analog_t ana_in,
  input  wire logic                   fault_n_in,
  input  wire logic                   hold_n_in,
  output logic                        fault_n_out,
  output logic                        fault_n_oe_out,
  output logic                        hold_n_out,
  output logic                        hold_n_oe_out,
  output logic                        ramp_up_out,
  output logic                        ramp_down_out,
  output logic                        shared_ramp_line_drive_out,
  output stfr_pkg::stfr_state_t       state_out
);
  import stfr_pkg::*;

  // ==========================================================
  // decode
  stfr_state_t state_ff;
  stfr_state_t nxt_state;
  logic        fault_ff;
  logic        nxt_fault;
  logic        fline_prev_ff;
  wire solo       = cfg_in.role == STFR_ROLE_SOLO;
  wire master     = cfg_in.role == STFR_ROLE_MASTER;
  // the comparator input is already hysteretic: high above the rising
  // threshold, low below the falling one
  wire run_ok     = enable_in && track_enable_comparator_input;
  wire sup_low    = |(cfg_in.track_sel & ~supply_ok_in);
  wire hold_low   = !hold_n_in;
  wire fline_low  = !fault_n_in;
  wire fline_rel  = fline_prev_ff && !fline_low;
  wire in_up      = state_ff == STFR_ST_UP;
  wire in_down    = state_ff == STFR_ST_DOWN;
  wire in_retry   = state_ff == STFR_ST_RETRY;
  // idle states hold the fault timer loaded, so only the step from up to
  // down needs a reload; decoding it from state and enables, not from
  // nxt_state, avoids a loop through the error decode
  wire seq_start  = in_up && !run_ok;
  wire gate_run   = solo && state_ff == STFR_ST_GATEWT;
  wire gate_load  = state_ff != STFR_ST_GATEWT;
  wire gate_done;
  wire flt_done;
  wire rty_done;
  // solo counts from own error assertion, group from shared line release
  wire rty_load   = solo ? (state_ff == STFR_ST_FAULT)
                         : (state_ff == STFR_ST_FAULT && fline_rel);
  wire flt_over   = (in_up || in_down) && flt_done;
  wire trk_err    = (in_up || in_down) && (ana_in.track_err || flt_over);

  // ==========================================================
  // timers
  stfr_timer u_gate
  (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .load_in  (gate_load),
    .run_in   (gate_run),
    .len_in   (`STFR_CNT_W'(`STFR_GATE_TO_CYC)),
    .done_out (gate_done)
  );
  // restarted at each sequence start, idle once tracked
  stfr_timer u_fault
  (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .load_in  (seq_start || !(in_up || in_down)),
    .run_in   ((in_up || in_down) && !ana_in.track_ok),
    .len_in   (`STFR_CNT_W'(`STFR_FAULT_CYC)),
    .done_out (flt_done)
  );
  stfr_timer u_retry
  (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .load_in  (rty_load),
    .run_in   (in_retry),
    .len_in   (`STFR_CNT_W'(`STFR_RETRY_CYC)),
    .done_out (rty_done)
  );

  // ==========================================================
  // sequencer
  wire may_start = run_ok && !sup_low && !hold_low;
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      STFR_ST_OFF:
        if (may_start)
          nxt_state = solo ? STFR_ST_GATEWT : STFR_ST_UP;
      STFR_ST_GATEWT:
        if (!may_start)
          nxt_state = STFR_ST_OFF;
        else if (gate_done)
          nxt_state = STFR_ST_UP;
      STFR_ST_UP:
        if (trk_err || fline_low)
          nxt_state = STFR_ST_FAULT;
        else if (!run_ok)
          nxt_state = STFR_ST_DOWN;
        else if (ana_in.ramp_done && ana_in.track_ok)
          nxt_state = STFR_ST_ON;
      STFR_ST_ON:
        if (!run_ok)
          nxt_state = STFR_ST_DOWN;
      STFR_ST_DOWN:
        if (trk_err)
          nxt_state = STFR_ST_FAULT;
        else if (ana_in.outs_low)
          nxt_state = STFR_ST_OFF;
      STFR_ST_FAULT:
        if (!cfg_in.auto_retry)
          nxt_state = STFR_ST_LATCHED;
        else if (rty_load)
          nxt_state = STFR_ST_RETRY;
      STFR_ST_RETRY:
        if (rty_done)
          nxt_state = STFR_ST_OFF;
      STFR_ST_LATCHED:
        nxt_state = STFR_ST_LATCHED;
      default:
        nxt_state = STFR_ST_OFF;
    endcase
  end

  // error flag held from detection until the retry count ends when solo, until it starts in master or slave role
  assign nxt_fault = (nxt_state == STFR_ST_FAULT) ||
                     (fault_ff && (nxt_state == STFR_ST_RETRY) && solo) ||
                     (nxt_state == STFR_ST_LATCHED);

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_ff      <= STFR_ST_OFF;
      fault_ff      <= 1'b0;
      fline_prev_ff <= 1'b0;
    end
    else
    begin
      state_ff      <= nxt_state;
      fault_ff      <= nxt_fault;
      fline_prev_ff <= fline_low;
    end
  end

  // ==========================================================
  // outputs
  // group members in fault release their own drive once they have seen the
  // shared line low, so it can go high once every peer has let go
  wire own_fault_drive = fault_ff && (solo || state_ff != STFR_ST_FAULT ||
                                      !fline_prev_ff);
  assign fault_n_out    = 1'b0;
  assign fault_n_oe_out = own_fault_drive;
  assign hold_n_out     = 1'b0;
  assign hold_n_oe_out  = sup_low || (master && in_retry);
  assign ramp_up_out    = in_up;
  assign ramp_down_out  = in_down || state_ff == STFR_ST_FAULT;
  assign shared_ramp_line_drive_out = master && (in_up || in_down);
  assign state_out      = state_ff;

  // ==========================================================
  // checks
  property p_gate_off;
    @(posedge clk_in) disable iff (!rst_n_in)
    !solo |-> state_ff != STFR_ST_GATEWT;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("gate timer ran");

  property p_solo_gate;
    @(posedge clk_in) disable iff (!rst_n_in)
    (solo && in_up && $changed(state_ff)) |->
      $past(state_ff) == STFR_ST_GATEWT && $past(gate_done);
  endproperty
  a_solo_gate: assert property (p_solo_gate) else $error("skipped gate");

  property p_hold_sup;
    @(posedge clk_in) disable iff (!rst_n_in)
    sup_low |-> hold_n_oe_out;
  endproperty
  a_hold_sup: assert property (p_hold_sup) else $error("hold not low");

  property p_hold_retry;
    @(posedge clk_in) disable iff (!rst_n_in)
    (master && in_retry) |-> hold_n_oe_out;
  endproperty
  a_hold_retry: assert property (p_hold_retry) else $error("hold off");

  property p_no_start_hold;
    @(posedge clk_in) disable iff (!rst_n_in)
    (hold_low && !in_up) |=> !in_up;
  endproperty
  a_no_start_hold: assert property (p_no_start_hold) else $error("hold start");

  property p_trk_down;
    @(posedge clk_in) disable iff (!rst_n_in)
    (state_ff == STFR_ST_ON && !run_ok) |=> in_down;
  endproperty
  a_trk_down: assert property (p_trk_down) else $error("no ramp down");

  property p_err_fault;
    @(posedge clk_in) disable iff (!rst_n_in)
    (in_up && ana_in.track_err) |=> state_ff == STFR_ST_FAULT ##0 fault_ff;
  endproperty
  a_err_fault: assert property (p_err_fault) else $error("no fault");

  property p_slave_ramp;
    @(posedge clk_in) disable iff (!rst_n_in)
    !master |-> !shared_ramp_line_drive_out;
  endproperty
  a_slave_ramp: assert property (p_slave_ramp) else $error("slave ramp");

  property p_latch;
    @(posedge clk_in) disable iff (!rst_n_in)
    (state_ff == STFR_ST_LATCHED) |=> (state_ff == STFR_ST_LATCHED) [*2];
  endproperty
  a_latch: assert property (p_latch) else $error("latch left");

  property p_solo_retry;
    @(posedge clk_in) disable iff (!rst_n_in)
    (solo && cfg_in.auto_retry && state_ff == STFR_ST_FAULT) |=> in_retry;
  endproperty
  a_solo_retry: assert property (p_solo_retry) else $error("retry");

  property p_grp_retry;
    @(posedge clk_in) disable iff (!rst_n_in)
    (!solo && state_ff == STFR_ST_FAULT && fline_low) |=> !in_retry;
  endproperty
  a_grp_retry: assert property (p_grp_retry) else $error("early");
endmodule
`default_nettype wire

// ===== bench/stfr_peer.sv
// peer tracker model on the shared wired fault and hold lines
`timescale 1ns/1ns
`default_nettype none
module stfr_peer
(
  input  wire logic pull_hold_in,
  input  wire logic pull_fault_in,
  input  wire logic dut_hold_oe_in,
  input  wire logic dut_fault_oe_in,
  output logic      hold_n_out,
  output logic      fault_n_out
);
  // ==========================================================
  // wired-low lines
  // a peer slave keeps hold low until its own inputs settle
  // pull-ups give the released level, so no stale value lingers
  assign hold_n_out  = ~(pull_hold_in | dut_hold_oe_in);
  assign fault_n_out = ~(pull_fault_in | dut_fault_oe_in);
endmodule
`default_nettype wire

// ===== bench/stfr_ctrl_tb_top.sv
// self-checking bench for the supply tracking fault/retry control
`timescale 1ns/1ns
`default_nettype none
module stfr_ctrl_tb_top;
  import stfr_pkg::*;
  logic         clk_in, rst_n_in, enable_in, trk, ph, pf, fn, hn;
  logic         f_oe, h_oe, r_up, r_dn, r_drv, fo, ho;
  logic [3:0]   sup;
  stfr_cfg_t    cfg;
  stfr_analog_t ana;
  stfr_state_t  st;
  int           bad_count, checked, n;
  // ==========================================================
  // design and peer
  stfr_ctrl stfr_ctrl_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .cfg_in(cfg), .enable_in(enable_in),
    .track_enable_comparator_input(trk), .supply_ok_in(sup),
    .ana_in(ana), .fault_n_in(fn), .hold_n_in(hn), .fault_n_out(fo),
    .fault_n_oe_out(f_oe), .hold_n_out(ho), .hold_n_oe_out(h_oe),
    .ramp_up_out(r_up), .ramp_down_out(r_dn),
    .shared_ramp_line_drive_out(r_drv), .state_out(st));
  stfr_peer stfr_peer_i (.pull_hold_in(ph), .pull_fault_in(pf),
    .dut_hold_oe_in(h_oe), .dut_fault_oe_in(f_oe),
    .hold_n_out(hn), .fault_n_out(fn));
  // ==========================================================
  // shared tasks
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [2:0] s, e);
    checked++;
    if (s !== e)
    begin
      $display("[ERR] %s exp %h seen %h", nm, e, s);
      bad_count++;
    end
  endtask
  // bounded wait for a state; a timeout ends the run
  // state is read at the edge, before it updates, so drives that follow
  // land on the rising edge
  task automatic go(input stfr_state_t s, input int mx);
    n = 0;
    while (st !== s && n < mx)
    begin
      @(posedge clk_in);
      n++;
    end
    if (st !== s)
    begin
      $display("[ERR] wait for state %h timed out", s);
      bad_count++;
      test_done();
    end
  endtask
  task automatic init(input stfr_role_t r, input logic ar);
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    cfg <= '{r, ar, 4'hF};
    enable_in <= 1'b0;
    trk <= 1'b1;
    sup <= 4'hF;
    ana <= '{1'b1, 1'b0, 1'b0, 1'b1};
    {ph, pf} <= 2'b00;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    enable_in <= 1'b1;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_solo();
    init(STFR_ROLE_SOLO, 1'b1);
    go(STFR_ST_GATEWT, 5);
    go(STFR_ST_UP, 40);
    check("gate wait", {2'b00, n >= 9}, 3'd1);
    check("ramp up", {2'b00, r_up}, 3'd1);
    ana.outs_low <= 1'b0;
    ana.ramp_done <= 1'b1;
    go(STFR_ST_ON, 5);
    enable_in <= 1'b0;
    go(STFR_ST_DOWN, 5);
    check("ramp down", {2'b00, r_dn}, 3'd1);
    ana.outs_low <= 1'b1;
    go(STFR_ST_OFF, 5);
    $display("solo sequence done");
  endtask
  // start is refused on low supply, comparator low or held line
  task automatic t_refuse();
    init(STFR_ROLE_SOLO, 1'b1);
    sup <= 4'hE;
    repeat (15) @(posedge clk_in);
    check("low supply", st, STFR_ST_OFF);
    check("hold drive", {2'b00, h_oe}, 3'd1);
    check("hold level", {2'b00, ho}, 3'd0);
    sup <= 4'hF;
    trk <= 1'b0;
    repeat (15) @(posedge clk_in);
    check("comp low", st, STFR_ST_OFF);
    check("hold free", {2'b00, h_oe}, 3'd0);
    trk <= 1'b1;
    ph <= 1'b1;
    repeat (15) @(posedge clk_in);
    check("peer hold", st, STFR_ST_OFF);
    ph <= 1'b0;
    go(STFR_ST_GATEWT, 5);
    $display("refusal test done");
  endtask
  task automatic t_master();
    init(STFR_ROLE_MASTER, 1'b1);
    go(STFR_ST_UP, 4);
    check("no gate", {2'b00, n <= 2}, 3'd1);
    check("ramp drive", {2'b00, r_drv}, 3'd1);
    pf <= 1'b1;
    go(STFR_ST_FAULT, 5);
    repeat (40) @(posedge clk_in);
    check("retry waits", st, STFR_ST_FAULT);
    pf <= 1'b0;
    go(STFR_ST_RETRY, 5);
    check("hold in retry", {2'b00, h_oe}, 3'd1);
    go(STFR_ST_OFF, 40);
    check("retry len", {2'b00, n >= 28}, 3'd1);
    $display("master test done");
  endtask
  task automatic t_slave();
    init(STFR_ROLE_SLAVE, 1'b1);
    go(STFR_ST_UP, 4);
    check("no ramp", {2'b00, r_drv}, 3'd0);
    ana.ramp_done <= 1'b1;
    go(STFR_ST_ON, 5);
    trk <= 1'b0;
    go(STFR_ST_DOWN, 5);
    $display("slave test done");
  endtask
  task automatic t_faults();
    init(STFR_ROLE_SOLO, 1'b1);
    go(STFR_ST_UP, 40);
    ana.track_err <= 1'b1;
    go(STFR_ST_FAULT, 3);
    check("fault out", {2'b00, f_oe}, 3'd1);
    ana.track_err <= 1'b0;
    go(STFR_ST_OFF, 45);
    check("retry from fault", {2'b00, n >= 29}, 3'd1);
    init(STFR_ROLE_SOLO, 1'b0);
    go(STFR_ST_UP, 40);
    ana.track_ok <= 1'b0;
    go(STFR_ST_FAULT, 30);
    check("fault period", {2'b00, n >= 19}, 3'd1);
    go(STFR_ST_LATCHED, 45);
    repeat (10) @(posedge clk_in);
    check("latched", st, STFR_ST_LATCHED);
    check("latched fault", {2'b00, f_oe}, 3'd1);
    check("fault level", {2'b00, fo}, 3'd0);
    $display("fault test done");
  endtask
  // ==========================================================
  // clock, reset and sequence
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial
  begin
    {bad_count, checked} = 0;
    {rst_n_in, enable_in, ph, pf} = 4'h0;
    trk = 1'b1;
    sup = 4'hF;
    cfg = '{STFR_ROLE_SOLO, 1'b1, 4'hF};
    ana = '{1'b1, 1'b0, 1'b0, 1'b1};
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    #1;
    check("reset state", st, STFR_ST_OFF);
    t_solo();
    t_refuse();
    t_master();
    t_slave();
    t_faults();
    test_done();
  end
endmodule
`default_nettype wire
